// ### rtl/ffl_regs.svh
// Register offsets, field positions, reset values and scaling constants
`ifndef FFL_REGS_SVH
`define FFL_REGS_SVH

// ==========================================================================
// Register byte offsets
`define FFL_OFF_CTRL 12'h000
`define FFL_OFF_BORE 12'h004
`define FFL_OFF_PFSEL 12'h008
`define FFL_OFF_BOT 12'h00C
`define FFL_OFF_TOP 12'h010
`define FFL_OFF_RANGE 12'h014
`define FFL_OFF_PV 12'h018
`define FFL_OFF_STAT 12'h01C
`define FFL_OFF_ISTAT 12'h020
`define FFL_OFF_IMASK 12'h024

// ==========================================================================
// Field positions
`define FFL_CTRL_VOL 0
`define FFL_CTRL_SEN 1
`define FFL_CTRL_UNIT_LSB 2
`define FFL_CTRL_UNIT_MSB 4
`define FFL_ST_BOT 0
`define FFL_ST_TOP 1
`define FFL_ST_WARN 2
`define FFL_ST_ALARM 3
`define FFL_ST_NEW 4

// ==========================================================================
// Reset values
`define FFL_RST_CTRL 5'h08
`define FFL_RST_BORE 16'h0000
`define FFL_RST_PFSEL 4'h0
`define FFL_RST_BOT 32'h0000_0000
`define FFL_RST_TOP 32'h2269_4E04
`define FFL_RST_RANGE 16'h3E80
`define FFL_RST_IMASK 5'h00

// ==========================================================================
// Scaling: quantities are hundredths, bore is tenths of a millimetre
`define FFL_VEL_MAX 16'h3E80
`define FFL_VOL_MAX 32'h2269_4E04
`define FFL_K_SHIFT 40
`define FFL_K_M3MIN 21'h00_0206
`define FFL_K_M3H 21'h00_7970
`define FFL_K_LS 21'h00_21BC
`define FFL_K_FT3MIN 21'h00_477A
`define FFL_K_FT3H 21'h10_C094

`endif

// ### rtl/ffl_pkg.sv
// Types shared by the flow process data formatter
package ffl_pkg;
  typedef enum logic [1:0] {
    ffl_st_idle = 2'b00,
    ffl_st_calc = 2'b01,
    ffl_st_load = 2'b11
  } ffl_state_t;
  typedef enum logic [2:0] {
    ffl_u_m3min = 3'h1,
    ffl_u_m3h = 3'h2,
    ffl_u_ls = 3'h3,
    ffl_u_ft3min = 3'h4,
    ffl_u_ft3h = 3'h5
  } ffl_unit_t;
endpackage

// ### rtl/ffl_vol_calc.sv
// Three-stage volume flow pipeline: unit factor, velocity product, scaling
`timescale 1ns/1ps
`include "ffl_regs.svh"
module ffl_vol_calc import ffl_pkg::*; (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic start, // Take operands this cycle
  input wire logic [15:0] vel, // Velocity, hundredths of m/s
  input wire logic [15:0] bore, // Inside diameter, tenths of mm
  input wire logic [9:0] pf, // Profile factor, thousandths
  input wire logic [2:0] unit, // Unit selection code
  output logic done, // Result valid, one cycle
  output logic [31:0] vol // Volume flow, hundredths
);
  logic [41:0] uf;
  logic [15:0] vel_q;
  logic [20:0] k_q;
  logic [57:0] prod;
  logic [20:0] k_p;
  logic s1;
  logic s2;
  logic [20:0] k_sel;
  logic [78:0] scaled;
  logic [38:0] vol_wide;

  // Unset codes fall back to m3/h so the output stays meaningful
  assign k_sel = (unit == ffl_u_m3min) ? `FFL_K_M3MIN :
                 (unit == ffl_u_ls) ? `FFL_K_LS :
                 (unit == ffl_u_ft3min) ? `FFL_K_FT3MIN :
                 (unit == ffl_u_ft3h) ? `FFL_K_FT3H : `FFL_K_M3H;
  assign scaled = prod * k_p;
  assign vol_wide = scaled[78:`FFL_K_SHIFT];

  // ========================================================================
  // Pipeline
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uf <= '0;
      vel_q <= '0;
      k_q <= '0;
      prod <= '0;
      k_p <= '0;
      s1 <= 1'b0;
      s2 <= 1'b0;
      done <= 1'b0;
      vol <= '0;
    end else if (ce) begin
      s1 <= start;
      s2 <= s1;
      done <= s2;
      if (start) begin
        uf <= 42'(pf * (bore * bore));
        vel_q <= vel;
        k_q <= k_sel;
      end
      if (s1) begin
        prod <= vel_q * uf;
        k_p <= k_q;
      end
      if (s2) begin
        // Saturate at the documented ceiling instead of wrapping
        vol <= (vol_wide > 39'(`FFL_VOL_MAX)) ? `FFL_VOL_MAX :
               vol_wide[31:0];
      end
    end
  end
endmodule

// ### rtl/ffl_top.sv
// Flow sensor process data formatter with APB register access
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
`include "ffl_regs.svh"
module ffl_top import ffl_pkg::*; (
  input wire logic pclk, // APB clock, 20 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic ce, // Clock enable, freezes all state
  input wire logic [11:0] paddr, // APB byte address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high for write
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [15:0] vel_in, // Measured velocity, hundredths
  input wire logic vel_stb, // New velocity sample, one cycle
  input wire logic sensor_fault, // Defective element, async pin
  output logic [31:0] proc_value, // Process value to the bus master
  output logic [7:0] status_byte, // Flag byte appended to data
  output logic status_en, // Flag byte is appended
  output logic pd_valid, // Process data refreshed, one cycle
  output logic irq // Interrupt, level
);
  // ========================================================================
  // Declarations
  logic [4:0] ctrl;
  logic [15:0] bore;
  logic [3:0] pf_sel;
  logic [31:0] bot_thr;
  logic [31:0] top_thr;
  logic [15:0] range_thr;
  logic [4:0] istat;
  logic [4:0] imask;
  logic [4:0] next_istat;
  logic fault_m;
  logic fault_s;
  logic [15:0] vel_q;
  logic mode_q;
  ffl_state_t st;
  ffl_state_t next_st;
  logic calc_done;
  logic [31:0] calc_vol;

  // ========================================================================
  // Profile factors, thousandths, held as constants (non-volatile)
  localparam logic [9:0] PF_ROM [16] = '{
    10'd796, 10'd770, 10'd748, 10'd757, 10'd763, 10'd772, 10'd775,
    10'd777, 10'd782, 10'd786, 10'd792, 10'd797, 10'd804, 10'd806,
    10'd812, 10'd817
  };
  wire [9:0] pf_val = PF_ROM[pf_sel];

  // ========================================================================
  // APB decode
  wire setup = psel & ~penable;
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire hit_ctrl = (paddr == `FFL_OFF_CTRL);
  wire hit_bore = (paddr == `FFL_OFF_BORE);
  wire hit_pfsel = (paddr == `FFL_OFF_PFSEL);
  wire hit_bot = (paddr == `FFL_OFF_BOT);
  wire hit_top = (paddr == `FFL_OFF_TOP);
  wire hit_range = (paddr == `FFL_OFF_RANGE);
  wire hit_pv = (paddr == `FFL_OFF_PV);
  wire hit_stat = (paddr == `FFL_OFF_STAT);
  wire hit_istat = (paddr == `FFL_OFF_ISTAT);
  wire hit_imask = (paddr == `FFL_OFF_IMASK);
  wire addr_ok = hit_ctrl | hit_bore | hit_pfsel | hit_bot | hit_top |
                 hit_range | hit_pv | hit_stat | hit_istat | hit_imask;
  wire [31:0] rd_mux =
    hit_ctrl ? {27'h000_0000, ctrl} :
    hit_bore ? {16'h0000, bore} :
    hit_pfsel ? {28'h000_0000, pf_sel} :
    hit_bot ? bot_thr :
    hit_top ? top_thr :
    hit_range ? {16'h0000, range_thr} :
    hit_pv ? proc_value :
    hit_stat ? {24'h00_0000, status_byte} :
    hit_istat ? {27'h000_0000, istat} :
    hit_imask ? {27'h000_0000, imask} : 32'h0000_0000;
  wire rd_istat = acc & ~pwrite & hit_istat;

  // ========================================================================
  // Sequencer and result selection
  wire [15:0] vel_clamp = (vel_in > `FFL_VEL_MAX) ? `FFL_VEL_MAX :
                          vel_in;
  wire start = (st == ffl_st_idle) & vel_stb;
  wire load = (st == ffl_st_load);
  wire [31:0] next_pv = mode_q ? calc_vol :
                        {16'h0000, vel_q};
  wire next_bot = next_pv < bot_thr;
  wire next_top = next_pv > top_thr;
  wire next_warn = vel_q > range_thr;
  wire next_alarm = fault_s;
  wire [7:0] next_stat = {4'h0, next_alarm, next_warn, next_top, next_bot};
  wire [4:0] events = {load, next_stat[3:0] & ~status_byte[3:0] &
                       {4{load}}};

  always_comb begin
    next_st = st;
    case (st)
      ffl_st_idle: begin
        if (vel_stb) begin
          next_st = ffl_st_calc;
        end
      end
      ffl_st_calc: begin
        if (calc_done) begin
          next_st = ffl_st_load;
        end
      end
      ffl_st_load: begin
        next_st = ffl_st_idle;
      end
      default: begin
        next_st = ffl_st_idle;
      end
    endcase
  end

  // Bore width of zero simply yields zero volume until software sets it
  ffl_vol_calc u_calc (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .start(start),
    .vel(vel_clamp),
    .bore(bore),
    .pf(pf_val),
    .unit(ctrl[`FFL_CTRL_UNIT_MSB:`FFL_CTRL_UNIT_LSB]),
    .done(calc_done),
    .vol(calc_vol)
  );

  // ========================================================================
  // Sticky interrupt bits: a new event wins over a read-clear, and only
  // the bits returned by the clearing read are dropped
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_istat
      assign next_istat[gi] = events[gi] |
                              (istat[gi] & ~(rd_istat & prdata[gi]));
    end
  endgenerate

  // ========================================================================
  // APB slave, no wait state; read data comes from a flop loaded in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (ce) begin
      pready <= setup;
      pslverr <= setup & ~addr_ok;
      if (setup & ~pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `FFL_RST_CTRL;
      bore <= `FFL_RST_BORE;
      pf_sel <= `FFL_RST_PFSEL;
      bot_thr <= `FFL_RST_BOT;
      top_thr <= `FFL_RST_TOP;
      range_thr <= `FFL_RST_RANGE;
      imask <= `FFL_RST_IMASK;
    end else if (ce && wr) begin
      if (hit_ctrl) ctrl <= pwdata[4:0];
      if (hit_bore) bore <= pwdata[15:0];
      if (hit_pfsel) pf_sel <= pwdata[3:0];
      if (hit_bot) bot_thr <= pwdata;
      if (hit_top) top_thr <= pwdata;
      if (hit_range) range_thr <= pwdata[15:0];
      if (hit_imask) imask <= pwdata[4:0];
    end
  end

  // ========================================================================
  // Fault pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_m <= 1'b0;
      fault_s <= 1'b0;
    end else if (ce) begin
      fault_m <= sensor_fault;
      fault_s <= fault_m;
    end
  end

  // ========================================================================
  // Process data: value and flags change at the same edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= ffl_st_idle;
      vel_q <= '0;
      mode_q <= 1'b0;
      proc_value <= '0;
      status_byte <= '0;
      status_en <= 1'b0;
      pd_valid <= 1'b0;
      istat <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      st <= next_st;
      pd_valid <= load;
      istat <= next_istat;
      irq <= |(istat & imask);
      if (start) begin
        vel_q <= vel_clamp;
        mode_q <= ctrl[`FFL_CTRL_VOL];
      end
      if (load) begin
        proc_value <= next_pv;
        status_byte <= next_stat;
        status_en <= ctrl[`FFL_CTRL_SEN];
      end
    end
  end

  // ========================================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // All checks except chk_vel_range, chk_calc_latency and chk_flags_sync skip any edge that follows a frozen cycle

  chk_bot_flag: assert property (
    ce && $past(ce) && pd_valid |->
      status_byte[`FFL_ST_BOT] == (proc_value < $past(bot_thr)))
    else $error("bottom flag disagrees with threshold");
  chk_top_flag: assert property (
    ce && $past(ce) && pd_valid |->
      status_byte[`FFL_ST_TOP] == (proc_value > $past(top_thr)))
    else $error("top flag disagrees with threshold");
  chk_warn_flag: assert property (
    ce && $past(ce) && pd_valid |->
      status_byte[`FFL_ST_WARN] == ($past(vel_q) > $past(range_thr)))
    else $error("warning flag disagrees with range");
  chk_alarm_flag: assert property (
    ce && $past(ce) && pd_valid |->
      status_byte[`FFL_ST_ALARM] == $past(fault_s))
    else $error("alarm flag disagrees with fault");
  chk_vel_range: assert property (
    vel_q <= `FFL_VEL_MAX)
    else $error("held velocity above ceiling");
  chk_vol_range: assert property (
    ce && $past(ce) && pd_valid && $past(mode_q) |->
      proc_value <= `FFL_VOL_MAX)
    else $error("volume above ceiling");
  chk_calc_latency: assert property (
    ce && start ##1 ce [*3] |-> calc_done)
    else $error("volume result late");
  chk_vel_mode: assert property (
    ce && $past(ce) && pd_valid && !$past(mode_q) |->
      proc_value == {16'h0000, $past(vel_q)})
    else $error("velocity mode value wrong");
  chk_flags_sync: assert property (
    ce && $changed(status_byte) |-> pd_valid)
    else $error("flags changed without process update");
  chk_status_en: assert property (
    ce && $past(ce) && pd_valid |->
      status_en == $past(ctrl[`FFL_CTRL_SEN]))
    else $error("status byte enable not taken");
  chk_irq_level: assert property (
    ce && $past(ce) && istat == 5'h00 ##1 ce |-> !irq)
    else $error("interrupt without status bit");

  cov_vol_update: cover property (
    ce && $past(ce) && pd_valid && $past(mode_q));
  cov_vel_update: cover property (
    ce && $past(ce) && pd_valid && !$past(mode_q));
  cov_top_flag: cover property (pd_valid && status_byte[`FFL_ST_TOP]);
  cov_irq_clear: cover property (irq ##[1:20] !irq);
endmodule

// ### tb/ffl_pd_master.sv
// Field bus master model taking each refreshed process data frame
`timescale 1ns/1ps
module ffl_pd_master (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic pd_valid, // Frame refreshed
  input wire logic [31:0] proc_value, // Process value
  input wire logic [7:0] status_byte, // Flag byte
  input wire logic status_en, // Flag byte appended
  output logic [31:0] pv, // Last value taken
  output logic [8:0] fb // Appended mark and flag byte
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pv <= 32'h0000_0000;
      fb <= 9'h000;
    end else if (pd_valid) begin
      pv <= proc_value;
      // Without the option only four bytes travel
      fb <= status_en ? {1'b1, status_byte} : 9'h000;
    end
  end
endmodule

// ### tb/test_flow_process_data_flags.sv
// Self-checking bench for the flow process data formatter
`timescale 1ns/1ps
`include "ffl_regs.svh"
module test_flow_process_data_flags;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, proc_value, pv, r;
  logic [15:0] vel_in = 16'h0000;
  logic vel_stb = 0, sensor_fault = 0, ce = 1, pready, pslverr, e;
  logic [7:0] status_byte;
  logic status_en, pd_valid, irq;
  logic [8:0] fb;
  int err_count = 0, check_count = 0, cyc = 0;
  always #25 pclk = ~pclk;
  ffl_top u_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vel_in(vel_in), .vel_stb(vel_stb), .sensor_fault(sensor_fault),
    .proc_value(proc_value), .status_byte(status_byte),
    .status_en(status_en), .pd_valid(pd_valid), .irq(irq));
  ffl_pd_master u_mst (.pclk(pclk), .presetn(presetn), .pd_valid(pd_valid),
    .proc_value(proc_value), .status_byte(status_byte),
    .status_en(status_en), .pv(pv), .fb(fb));
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait states are the slave's; only the cycle ceiling ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(a, 1'b0, 32'h0000_0000);
    chk(r, x);
  endtask
  // Strobe one sample, check latency, value and flag byte at the master
  task automatic sample(input logic [15:0] v, input logic [31:0] x,
                        input logic [8:0] f);
    int n;
    n = 0;
    @(posedge pclk);
    vel_in <= v;
    vel_stb <= 1'b1;
    @(posedge pclk);
    vel_stb <= 1'b0;
    do begin
      @(negedge pclk);
      n++;
    end while (pd_valid !== 1'b1 && n < 50);
    chk(n, 5);
    @(negedge pclk);
    chk(pv, x);
    chk(fb, f);
  endtask
  function automatic logic [31:0] vexp(input logic [15:0] v,
      input logic [15:0] b, input logic [9:0] p, input logic [2:0] u);
    logic [127:0] q;
    logic [20:0] k;
    case (u)
      3'h1: k = `FFL_K_M3MIN;
      3'h3: k = `FFL_K_LS;
      3'h4: k = `FFL_K_FT3MIN;
      3'h5: k = `FFL_K_FT3H;
      default: k = `FFL_K_M3H;
    endcase
    q = (128'(v) * 128'(p) * 128'(b) * 128'(b) * 128'(k)) >> 40;
    return (q > 128'(`FFL_VOL_MAX)) ? `FFL_VOL_MAX : q[31:0];
  endfunction
  logic [15:0] tv [6] = '{16'd999, 16'd1000, 16'd4000, 16'd4001,
                          16'd5000, 16'd5001};
  logic [7:0] ts [6] = '{8'h01, 8'h00, 8'h00, 8'h04, 8'h04, 8'h06};
  logic [31:0] vx;
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(proc_value, 32'h0000_0000);
    rd(`FFL_OFF_CTRL, 32'h0000_0008);
    rd(`FFL_OFF_BORE, 32'h0000_0000);
    rd(`FFL_OFF_PFSEL, 32'h0000_0000);
    rd(`FFL_OFF_BOT, 32'h0000_0000);
    rd(`FFL_OFF_TOP, `FFL_RST_TOP);
    rd(`FFL_OFF_RANGE, 32'h0000_3E80);
    rd(`FFL_OFF_STAT, 32'h0000_0000);
    rd(`FFL_OFF_IMASK, 32'h0000_0000);
    wr(`FFL_OFF_PV, 32'hFFFF_FFFF);
    rd(`FFL_OFF_PV, 32'h0000_0000);
    rd(12'h030, 32'h0000_0000);
    chk(e, 1);
    $display("test reset done");
    sample(16'd100, 32'd100, 9'h000);
    chk(irq, 0);
    wr(`FFL_OFF_IMASK, 32'h0000_0010);
    repeat (2) @(negedge pclk);
    chk(irq, 1);
    rd(`FFL_OFF_ISTAT, 32'h0000_0010);
    repeat (2) @(negedge pclk);
    chk(irq, 0);
    rd(`FFL_OFF_ISTAT, 32'h0000_0000);
    $display("test interrupt done");
    // A strobe while frozen must be dropped, leaving no refresh behind
    @(posedge pclk);
    ce <= 1'b0;
    vel_in <= 16'd200;
    vel_stb <= 1'b1;
    @(posedge pclk);
    vel_stb <= 1'b0;
    repeat (8) @(posedge pclk);
    ce <= 1'b1;
    rd(`FFL_OFF_ISTAT, 32'h0000_0000);
    chk(pv, 32'd100);
    $display("test freeze done");
    wr(`FFL_OFF_CTRL, 32'h0000_000A);
    wr(`FFL_OFF_BOT, 32'd1000);
    wr(`FFL_OFF_TOP, 32'd5000);
    wr(`FFL_OFF_RANGE, 32'd4000);
    for (int i = 0; i < 6; i++) begin
      sample(tv[i], 32'(tv[i]), {1'b1, ts[i]});
    end
    @(posedge pclk);
    sensor_fault <= 1'b1;
    repeat (3) @(posedge pclk);
    sample(16'd4001, 32'd4001, 9'h10C);
    @(posedge pclk);
    sensor_fault <= 1'b0;
    $display("test flags done");
    wr(`FFL_OFF_BORE, 32'd1000);
    wr(`FFL_OFF_PFSEL, 32'h0000_0000);
    wr(`FFL_OFF_BOT, 32'd30000);
    wr(`FFL_OFF_TOP, `FFL_VOL_MAX);
    for (int u = 0; u < 8; u++) begin
      wr(`FFL_OFF_CTRL, 32'(u << 2) | 32'h0000_0003);
      vx = vexp(16'd1000, 16'd1000, 10'd796, 3'(u));
      sample(16'd1000, vx, {1'b1, 7'h00, vx < 32'd30000});
    end
    wr(`FFL_OFF_BORE, 32'd65535);
    wr(`FFL_OFF_PFSEL, 32'h0000_000F);
    wr(`FFL_OFF_CTRL, 32'h0000_0017);
    chk(vexp(16'd16000, 16'd65535, 10'd817, 3'h5), `FFL_VOL_MAX);
    sample(16'd16000, `FFL_VOL_MAX, 9'h104);
    $display("test volume done");
    final_report();
  end
endmodule
